// ==== src/mrc_pkg.sv ====
package mrc_pkg;

    // ****************************************
    // Register map and field positions
    // ****************************************
    localparam logic [3:0] RCV_CTRL_OFS  = 4'h4;
    localparam logic [3:0] STATS_OFS     = 4'h6;
    localparam logic [3:0] MEM_INFO_OFS  = 4'h8;
    localparam logic [3:0] MEM_CFG_OFS   = 4'ha;
    localparam int         RC_SOFT_RST   = 15;
    localparam int         RC_CARRIER_EDGE_FILTER   = 14;
    localparam int         RC_DROP_FRAME_CHECKSUM  = 9;
    localparam int         RC_RX_ENABLE  = 8;
    localparam int         RC_ALL_MCAST  = 2;
    localparam int         RC_PROMISC    = 1;
    localparam int         RC_RX_ABORT   = 0;

    // ****************************************
    // Constant values
    // ****************************************
    localparam logic [7:0]  MEM_SIZE_PAGES  = 8'h18;
    localparam logic [7:0]  MEM_CFG_HIGH    = 8'h33;
    localparam logic [3:0]  CNT_MAX         = 4'hf;
    localparam logic [4:0]  FATAL_COLL      = 5'h10;
    localparam logic [10:0] MAX_FRAME_BYTES = 11'h5fc;

    // ****************************************
    // Timing
    // ****************************************
    localparam int         CLK_PERIOD_NS  = 10;
    localparam int         BIT_TIME_NS    = 100;
    localparam int         FILT_BITS      = 12;
    localparam int         FILT_CYC_INT   =
        (FILT_BITS * BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] FILT_CYCLES    = 8'(FILT_CYC_INT);

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_FRAME = 2'b01,
        RX_DROP  = 2'b10
    } mrc_rx_state_t;

    typedef struct packed {
        logic [4:0] coll;
        logic       sqet_fail;
        logic       underrun;
        logic       carrier_lost;
        logic       late_coll;
        logic       deferred;
        logic       exc_deferred;
    } mrc_tx_stat_t;

    typedef struct packed {
        logic multicast;
        logic mcast_hit;
        logic addr_hit;
        logic own_source;
    } mrc_rx_hdr_t;

    typedef struct packed {
        logic             soft_rst;
        logic             filt;
        logic             strip;
        logic             receiver_enable;
        logic             accept_all_multicast;
        logic             promiscuous_receive;
        logic             abort;
        logic [3:0][3:0]  cnt;
        logic             rollover;
        logic             stat_irq;
        logic [7:0]       free;
        logic [7:0]       reserve;
        logic [15:0]      rdata;
        logic             crs_m;
        logic             crs_s;
        logic             carrier;
        logic [7:0]       filt_cnt;
        mrc_rx_state_t    rx_st;
        logic [10:0]      byte_cnt;
        logic             accept;
        logic             abort_pls;
        logic             done_pls;
        logic             fatal;
        logic             booted;
        logic             reload;
        logic             alloc_ok;
        logic             alloc_deny;
    } mrc_state_t;

    localparam mrc_state_t STATE_RST = '{
        free    : MEM_SIZE_PAGES,
        rx_st   : RX_IDLE,
        default : '0
    };

endpackage : mrc_pkg

// ==== src/mrc_bank0.sv ====
// Decided for this implementation: the strobed register port.
`timescale 1ns/100ps

module mrc_bank0 (
    input  wire logic                  clk_i,
    input  wire logic                  srst_i,
    input  wire logic [3:0]            addr_i,
    input  wire logic [15:0]           wdata_i,
    input  wire logic                  wr_i,
    input  wire logic                  rd_i,
    output logic      [15:0]           rdata_o,
    input  wire logic                  tx_done_i,
    input  wire mrc_pkg::mrc_tx_stat_t tx_stat_i,
    input  wire logic                  stop_on_quality_test_error_i,
    input  wire logic                  carrier_monitor_enable_i,
    input  wire logic                  full_duplex_enable_i,
    output logic                       tx_fatal_o,
    input  wire logic                  crs_i,
    output logic                       rx_carrier_o,
    input  wire logic                  rx_start_i,
    input  wire mrc_pkg::mrc_rx_hdr_t  rx_hdr_i,
    input  wire logic                  rx_byte_i,
    input  wire logic                  rx_end_i,
    output logic                       rx_accept_o,
    output logic                       rx_abort_o,
    output logic                       rx_done_o,
    output logic                       rx_active_o,
    output logic                       drop_frame_checksum_o,
    output logic                       stat_irq_o,
    output logic                       counter_rollover_o,
    input  wire logic                  alloc_req_i,
    input  wire logic                  alloc_rx_i,
    input  wire logic                  release_i,
    input  wire logic                  buffer_manager_reinit_cmd_i,
    output logic                       alloc_ok_o,
    output logic                       alloc_deny_o,
    output logic                       soft_reset_o,
    output logic                       eeprom_reload_o
);

    // ****************************************
    // State
    // ****************************************
    mrc_pkg::mrc_state_t q;
    mrc_pkg::mrc_state_t d;
    logic [3:0]          inc;
    logic                accepted;
    logic                grant;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        d            = q;
        inc          = '0;
        accepted     = 1'b0;
        grant        = 1'b0;
        d.stat_irq   = 1'b0;
        d.fatal      = 1'b0;
        d.accept     = 1'b0;
        d.abort_pls  = 1'b0;
        d.done_pls   = 1'b0;
        d.alloc_ok   = 1'b0;
        d.alloc_deny = 1'b0;
        d.reload     = 1'b0;
        d.rdata      = '0;

        // Soft reset image, without an EEPROM reload
        if (q.soft_rst) begin
            d          = mrc_pkg::STATE_RST;
            d.soft_rst = 1'b1;
            d.booted   = 1'b1;
        end

        // Reload request only after a hard reset
        if (!q.booted) begin
            d.booted = 1'b1;
            d.reload = 1'b1;
        end

        // Carrier sense synchroniser
        d.crs_m = crs_i;
        d.crs_s = q.crs_m;

        // Carrier edge filter
        if (!q.crs_s) begin
            d.carrier  = 1'b0;
            d.filt_cnt = '0;
        end else if (!q.filt) begin
            d.carrier = 1'b1;
        end else if (q.filt_cnt == mrc_pkg::FILT_CYCLES - 8'h01) begin
            d.carrier = 1'b1;
        end else if (!q.carrier) begin
            d.filt_cnt = q.filt_cnt + 8'h01;
        end

        // Register reads
        if (rd_i) begin
            unique case (addr_i)
                mrc_pkg::RCV_CTRL_OFS: begin
                    d.rdata[mrc_pkg::RC_SOFT_RST]  = q.soft_rst;
                    d.rdata[mrc_pkg::RC_CARRIER_EDGE_FILTER]  = q.filt;
                    d.rdata[mrc_pkg::RC_DROP_FRAME_CHECKSUM] = q.strip;
                    d.rdata[mrc_pkg::RC_RX_ENABLE] = q.receiver_enable;
                    d.rdata[mrc_pkg::RC_ALL_MCAST] = q.accept_all_multicast;
                    d.rdata[mrc_pkg::RC_PROMISC]   = q.promiscuous_receive;
                    d.rdata[mrc_pkg::RC_RX_ABORT]  = q.abort;
                end
                mrc_pkg::STATS_OFS: begin
                    d.rdata = q.cnt;
                end
                mrc_pkg::MEM_INFO_OFS: begin
                    d.rdata = {mrc_pkg::MEM_SIZE_PAGES, q.free};
                end
                mrc_pkg::MEM_CFG_OFS: begin
                    d.rdata = {mrc_pkg::MEM_CFG_HIGH, q.reserve};
                end
                default: begin
                    d.rdata = '0;
                end
            endcase
        end

        // Receive control writes
        if (wr_i && addr_i == mrc_pkg::RCV_CTRL_OFS) begin
            d.soft_rst = wdata_i[mrc_pkg::RC_SOFT_RST];
            d.filt     = wdata_i[mrc_pkg::RC_CARRIER_EDGE_FILTER];
            d.strip    = wdata_i[mrc_pkg::RC_DROP_FRAME_CHECKSUM];
            d.receiver_enable     = wdata_i[mrc_pkg::RC_RX_ENABLE];
            d.accept_all_multicast    = wdata_i[mrc_pkg::RC_ALL_MCAST];
            d.promiscuous_receive     = wdata_i[mrc_pkg::RC_PROMISC];
            if (!wdata_i[mrc_pkg::RC_RX_ABORT]) begin
                d.abort = 1'b0;
            end
        end

        // Reservation write
        if (wr_i && addr_i == mrc_pkg::MEM_CFG_OFS) begin
            d.reserve = wdata_i[7:0];
        end

        // Fatal transmit conditions
        if (tx_done_i && !q.soft_rst) begin
            d.fatal = (tx_stat_i.coll == mrc_pkg::FATAL_COLL)
                    | (tx_stat_i.sqet_fail & stop_on_quality_test_error_i)
                    | tx_stat_i.underrun
                    | (tx_stat_i.carrier_lost & carrier_monitor_enable_i)
                    | tx_stat_i.late_coll;
        end

        // One increment per counter per cycle with tx_done_i high
        if (tx_done_i && !q.soft_rst) begin
            inc[0] = (tx_stat_i.coll == 5'h01);
            inc[1] = (tx_stat_i.coll >= 5'h02)
                   && (tx_stat_i.coll <= mrc_pkg::FATAL_COLL);
            inc[2] = tx_stat_i.deferred;
            inc[3] = tx_stat_i.exc_deferred;
        end

        // Clear on read, then saturating increments
        if (rd_i && addr_i == mrc_pkg::STATS_OFS) begin
            d.cnt      = '0;
            d.rollover = 1'b0;
        end
        for (int i = 0; i < 4; i++) begin
            if (inc[i] && d.cnt[i] != mrc_pkg::CNT_MAX) begin
                d.cnt[i] = d.cnt[i] + 4'h1;
                if (d.cnt[i] == mrc_pkg::CNT_MAX) begin
                    d.rollover = 1'b1;
                    d.stat_irq = 1'b1;
                end
            end
        end

        // Address filter
        accepted = (rx_hdr_i.addr_hit && !rx_hdr_i.multicast)
                 | (rx_hdr_i.multicast
                    && (q.accept_all_multicast || rx_hdr_i.mcast_hit))
                 | q.promiscuous_receive;
        if (rx_hdr_i.own_source && !full_duplex_enable_i) begin
            accepted = 1'b0;
        end

        // Receive frame tracking
        if (!q.soft_rst) begin
            unique case (q.rx_st)
                mrc_pkg::RX_IDLE: begin
                    if (rx_start_i && q.receiver_enable) begin
                        d.byte_cnt = '0;
                        d.accept   = accepted;
                        d.rx_st    = accepted ? mrc_pkg::RX_FRAME
                                              : mrc_pkg::RX_DROP;
                    end
                end
                mrc_pkg::RX_FRAME: begin
                    if (rx_end_i) begin
                        d.done_pls = 1'b1;
                        d.rx_st    = mrc_pkg::RX_IDLE;
                    end else if (rx_byte_i) begin
                        if (q.byte_cnt == mrc_pkg::MAX_FRAME_BYTES) begin
                            d.abort     = 1'b1;
                            d.abort_pls = 1'b1;
                            d.rx_st     = mrc_pkg::RX_DROP;
                        end else begin
                            d.byte_cnt = q.byte_cnt + 11'h001;
                        end
                    end
                end
                mrc_pkg::RX_DROP: begin
                    if (rx_end_i) begin
                        d.rx_st = mrc_pkg::RX_IDLE;
                    end
                end
                default: begin
                    d.rx_st = mrc_pkg::RX_IDLE;
                end
            endcase
        end

        // Buffer allocation against the reservation
        if (alloc_req_i && !q.soft_rst) begin
            grant = (q.free != 8'h00)
                  && (!alloc_rx_i || q.reserve == 8'h00
                      || q.free > q.reserve);
            d.alloc_ok   = grant;
            d.alloc_deny = !grant;
        end
        if (!q.soft_rst) begin
            if (grant && !release_i) begin
                d.free = q.free - 8'h01;
            end else if (!grant && release_i
                         && q.free != mrc_pkg::MEM_SIZE_PAGES) begin
                d.free = q.free + 8'h01;
            end
        end
        if (buffer_manager_reinit_cmd_i) begin
            d.free = mrc_pkg::MEM_SIZE_PAGES;
        end
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            q <= mrc_pkg::STATE_RST;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from the state register
    assign rdata_o               = q.rdata;
    assign tx_fatal_o            = q.fatal;
    assign rx_carrier_o          = q.carrier;
    assign rx_accept_o           = q.accept;
    assign rx_abort_o            = q.abort_pls;
    assign rx_done_o             = q.done_pls;
    assign rx_active_o           = q.rx_st[0];                       // Only code 01 sets bit 0
    assign drop_frame_checksum_o = q.strip;
    assign stat_irq_o            = q.stat_irq;
    assign counter_rollover_o    = q.rollover;
    assign alloc_ok_o            = q.alloc_ok;
    assign alloc_deny_o          = q.alloc_deny;
    assign soft_reset_o          = q.soft_rst;
    assign eeprom_reload_o       = q.reload;

    // ****************************************
    // Assertions
    // ****************************************
    property p_fatal_underrun;
        @(posedge clk_i) disable iff (srst_i)
        tx_done_i && tx_stat_i.underrun && !q.soft_rst |=> tx_fatal_o;
    endproperty
    a_fatal_underrun: assert property (p_fatal_underrun)
        else $error("underrun not fatal");

    property p_soft_no_reload;
        @(posedge clk_i) disable iff (srst_i)
        q.soft_rst |=> !eeprom_reload_o;
    endproperty
    a_soft_no_reload: assert property (p_soft_no_reload)
        else $error("soft reset asked for reload");

    property p_filter_wait;
        @(posedge clk_i) disable iff (srst_i)
        $rose(rx_carrier_o) && $past(q.filt) && $past(q.crs_s)
            |-> $past(q.filt_cnt) == mrc_pkg::FILT_CYCLES - 8'h01;
    endproperty
    a_filter_wait: assert property (p_filter_wait)
        else $error("carrier filter too short");

    property p_rx_disabled;
        @(posedge clk_i) disable iff (srst_i)
        q.rx_st == mrc_pkg::RX_IDLE && !q.receiver_enable |=> !rx_accept_o && !rx_active_o;
    endproperty
    a_rx_disabled: assert property (p_rx_disabled)
        else $error("frame taken while disabled");

    property p_abort_flag;
        @(posedge clk_i) disable iff (srst_i)
        rx_abort_o |-> q.abort && !rx_active_o;
    endproperty
    a_abort_flag: assert property (p_abort_flag)
        else $error("oversize without flag");

    property p_saturate;
        @(posedge clk_i) disable iff (srst_i)
        q.cnt[0] == mrc_pkg::CNT_MAX && !rd_i && !q.soft_rst
            |=> q.cnt[0] == mrc_pkg::CNT_MAX;
    endproperty
    a_saturate: assert property (p_saturate)
        else $error("counter wrapped");

    property p_read_clears;
        @(posedge clk_i) disable iff (srst_i)
        rd_i && addr_i == mrc_pkg::STATS_OFS && !tx_done_i |=> q.cnt == '0;
    endproperty
    a_read_clears: assert property (p_read_clears)
        else $error("counters not cleared by read");

    property p_size_const;
        @(posedge clk_i) disable iff (srst_i)
        rd_i && addr_i == mrc_pkg::MEM_INFO_OFS |=> rdata_o[15:8] == 8'h18;
    endproperty
    a_size_const: assert property (p_size_const)
        else $error("memory size wrong");

    property p_rx_denied;
        @(posedge clk_i) disable iff (srst_i)
        alloc_req_i && alloc_rx_i && q.reserve != 8'h00 && q.free <= q.reserve
            && !q.soft_rst |=> alloc_deny_o && !alloc_ok_o;
    endproperty
    a_rx_denied: assert property (p_rx_denied)
        else $error("receive allocation not denied");

    property p_reinit_keeps;
        @(posedge clk_i) disable iff (srst_i)
        buffer_manager_reinit_cmd_i && !wr_i && !q.soft_rst
            |=> q.reserve == $past(q.reserve) && q.free == 8'h18;
    endproperty
    a_reinit_keeps: assert property (p_reinit_keeps)
        else $error("reinit handled wrongly");

    property p_multi_count;
        @(posedge clk_i) disable iff (srst_i)
        tx_done_i && !q.soft_rst && !rd_i && q.cnt[1] != mrc_pkg::CNT_MAX
            && tx_stat_i.coll >= 5'h02 && tx_stat_i.coll <= mrc_pkg::FATAL_COLL
            |=> q.cnt[1] == $past(q.cnt[1]) + 4'h1;
    endproperty
    a_multi_count: assert property (p_multi_count)
        else $error("multiple collision count not advanced");

    property p_defer_once;
        @(posedge clk_i) disable iff (srst_i)
        tx_done_i && tx_stat_i.deferred && !q.soft_rst && !rd_i
            && q.cnt[2] != mrc_pkg::CNT_MAX
            |=> q.cnt[2] == $past(q.cnt[2]) + 4'h1;
    endproperty
    a_defer_once: assert property (p_defer_once)
        else $error("deferral count not advanced once");

endmodule : mrc_bank0

// ==== sim/mrc_host.sv ====
`timescale 1ns/100ps
// ********
// Host processor model on the register bus
// ********
module mrc_host (
    input  wire logic        clk_i,
    input  wire logic [15:0] rdata_i,
    output logic      [3:0]  addr_o,
    output logic      [15:0] wdata_o,
    output logic             wr_o,
    output logic             rd_o
);
    // Bus idle from time zero
    initial begin
        {addr_o, wdata_o, wr_o, rd_o} = '0;
    end
    // One-cycle write; stale data is inverted so it cannot pass for a hold
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr_o  <= a;
        wdata_o <= d;
        wr_o    <= 1'b1;
        @(posedge clk_i);
        wr_o    <= 1'b0;
        wdata_o <= ~d;
    endtask : wr_reg
    // One-cycle read; data taken in the cycle after the strobe
    task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_i);
        addr_o <= a;
        rd_o   <= 1'b1;
        @(posedge clk_i);
        rd_o   <= 1'b0;
        #1;
        d = rdata_i;
    endtask : rd_reg
endmodule : mrc_host

// ==== sim/mac_rx_control_stats_memory_bench.sv ====
`timescale 1ns/100ps
module mac_rx_control_stats_memory_bench;
    localparam logic [3:0] RCV = mrc_pkg::RCV_CTRL_OFS;
    localparam logic [3:0] STA = mrc_pkg::STATS_OFS;
    localparam logic [3:0] MIN = mrc_pkg::MEM_INFO_OFS;
    localparam logic [3:0] MCF = mrc_pkg::MEM_CFG_OFS;
    logic                  clk_i, srst_i, wr, rd, tx_done, sqet_en, mon_en, fdx, crs;
    logic                  rx_start, rx_byte, rx_end, alloc_req, alloc_rx, rel, reinit;
    logic [3:0]            addr;
    logic [15:0]           wdata, rdata;
    mrc_pkg::mrc_tx_stat_t tx_stat;
    mrc_pkg::mrc_rx_hdr_t  rx_hdr;
    logic                  fatal, carrier, acc, abrt, done, act, strip, irq, roll;
    logic                  aok, adeny, srst_o, reload;
    int                    n_mismatch = 0, n_checks = 0, n_irq = 0, n_abort = 0, n_reload = 0;
    // Rows: packet status, quality/carrier gates, fatal, statistics word
    logic [29:0]           rows [10] = '{
        {11'h040, 2'b00, 1'b0, 16'h0001},
        {11'h082, 2'b00, 1'b0, 16'h0110},
        {11'h400, 2'b00, 1'b1, 16'h0010},
        {11'h003, 2'b00, 1'b0, 16'h1100},
        {11'h010, 2'b00, 1'b1, 16'h0000},
        {11'h004, 2'b00, 1'b1, 16'h0000},
        {11'h020, 2'b00, 1'b0, 16'h0000},
        {11'h020, 2'b10, 1'b1, 16'h0000},
        {11'h008, 2'b00, 1'b0, 16'h0000},
        {11'h008, 2'b01, 1'b1, 16'h0000}};
    mrc_host host (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata), .wr_o(wr),
        .rd_o(rd));
    mrc_bank0 dut (
        .clk_i(clk_i), .srst_i(srst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata), .tx_done_i(tx_done), .tx_stat_i(tx_stat),
        .stop_on_quality_test_error_i(sqet_en), .carrier_monitor_enable_i(mon_en),
        .full_duplex_enable_i(fdx), .tx_fatal_o(fatal), .crs_i(crs), .rx_carrier_o(carrier),
        .rx_start_i(rx_start), .rx_hdr_i(rx_hdr), .rx_byte_i(rx_byte), .rx_end_i(rx_end),
        .rx_accept_o(acc), .rx_abort_o(abrt), .rx_done_o(done), .rx_active_o(act),
        .drop_frame_checksum_o(strip), .stat_irq_o(irq), .counter_rollover_o(roll),
        .alloc_req_i(alloc_req), .alloc_rx_i(alloc_rx), .release_i(rel),
        .buffer_manager_reinit_cmd_i(reinit), .alloc_ok_o(aok), .alloc_deny_o(adeny),
        .soft_reset_o(srst_o), .eeprom_reload_o(reload));
    // Clock
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // Hang guard
    initial begin
        repeat (100000) @(posedge clk_i);
        n_mismatch++;
        give_verdict();
    end
    // Pulse counters for outputs whose cycle is the design's choice
    always @(posedge clk_i) begin
        n_irq    += (irq === 1'b1);
        n_abort  += (abrt === 1'b1);
        n_reload += (reload === 1'b1);
    end
    // ********
    // Shared tasks
    // ********
    task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] s);
        n_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask : chk16
    task automatic chk1(input string nm, input logic e, input logic s);
        n_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %b seen %b", nm, e, s);
        end
    endtask : chk1
    task automatic rchk(input logic [3:0] a, input logic [15:0] e);
        logic [15:0] d;
        host.rd_reg(a, d);
        chk16("register", e, d);
    endtask : rchk
    task automatic tx_pkt(input logic [10:0] st, input logic [1:0] g, input int n);
        @(posedge clk_i);
        tx_stat           <= mrc_pkg::mrc_tx_stat_t'(st);
        {sqet_en, mon_en} <= g;
        tx_done           <= 1'b1;
        repeat (n) @(posedge clk_i);
        tx_done <= 1'b0;
        #1;
    endtask : tx_pkt
    task automatic frame(input logic [3:0] h, input int nb, input logic ok);
        @(posedge clk_i);
        rx_start <= 1'b1;
        rx_hdr   <= mrc_pkg::mrc_rx_hdr_t'(h);
        @(posedge clk_i);
        rx_start <= 1'b0;
        rx_byte  <= 1'b1;
        #1;
        chk1("accept", ok, acc);
        chk1("active", ok, act);
        repeat (nb) @(posedge clk_i);
        rx_byte <= 1'b0;
        rx_end  <= 1'b1;
        @(posedge clk_i);
        rx_end <= 1'b0;
        #1;
        chk1("done", ok && nb < 1533, done);
    endtask : frame
    task automatic alloc(input logic r, input logic ok);
        @(posedge clk_i);
        alloc_req <= 1'b1;
        alloc_rx  <= r;
        @(posedge clk_i);
        alloc_req <= 1'b0;
        #1;
        chk1("alloc_ok", ok, aok);
        chk1("alloc_deny", !ok, adeny);
    endtask : alloc
    task automatic mm_cmd(input logic r);
        @(posedge clk_i);
        rel    <= r;
        reinit <= !r;
        @(posedge clk_i);
        rel    <= 1'b0;
        reinit <= 1'b0;
    endtask : mm_cmd
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : give_verdict
    // ********
    // Main sequence
    // ********
    initial begin
        srst_i = 1'b1;
        {tx_done, sqet_en, mon_en, fdx, crs, rx_start, rx_byte, rx_end} = '0;
        {alloc_req, alloc_rx, rel, reinit, tx_stat, rx_hdr} = '0;
        repeat (20) @(posedge clk_i);
        srst_i <= 1'b0;
        foreach (rows[i]) begin
            tx_pkt(rows[i][29:19], rows[i][18:17], 1);
            chk1("fatal", rows[i][16], fatal);
            rchk(STA, rows[i][15:0]);
        end
        rchk(MIN, 16'h1818);
        rchk(MCF, 16'h3300);
        rchk(4'hc, 16'h0000);
        tx_pkt(11'h040, 2'b00, 16);
        chk1("rollover", 1'b1, roll);
        rchk(STA, 16'h000f);
        chk16("irqs", 16'h0001, 16'(n_irq));
        chk1("rollover", 1'b0, roll);
        host.wr_reg(RCV, 16'h0301);
        rchk(RCV, 16'h0300);
        chk1("strip", 1'b1, strip);
        frame(4'b0010, 4, 1'b1);
        frame(4'b1000, 4, 1'b0);
        frame(4'b1100, 4, 1'b1);
        frame(4'b0000, 4, 1'b0);
        host.wr_reg(RCV, 16'h0304);
        frame(4'b1000, 4, 1'b1);
        frame(4'b0000, 4, 1'b0);
        host.wr_reg(RCV, 16'h0306);
        frame(4'b0000, 4, 1'b1);
        frame(4'b0001, 4, 1'b0);
        @(posedge clk_i);
        fdx <= 1'b1;
        frame(4'b0001, 4, 1'b1);
        frame(4'b0010, 1532, 1'b1);
        chk16("aborts", 16'h0000, 16'(n_abort));
        frame(4'b0010, 1533, 1'b1);
        chk16("aborts", 16'h0001, 16'(n_abort));
        rchk(RCV, 16'h0307);
        host.wr_reg(RCV, 16'h0106);
        rchk(RCV, 16'h0106);
        chk1("strip", 1'b0, strip);
        @(posedge clk_i);
        crs <= 1'b1;
        repeat (3) @(negedge clk_i);
        chk1("carrier", 1'b0, carrier);
        @(negedge clk_i);
        chk1("carrier", 1'b1, carrier);
        @(posedge clk_i);
        crs <= 1'b0;
        host.wr_reg(RCV, 16'h4100);
        frame(4'b0010, 4, 1'b1);
        @(posedge clk_i);
        crs <= 1'b1;
        repeat (mrc_pkg::FILT_CYC_INT + 2) @(negedge clk_i);
        chk1("carrier", 1'b0, carrier);
        @(negedge clk_i);
        chk1("carrier", 1'b1, carrier);
        @(posedge clk_i);
        crs <= 1'b0;
        // Receiver disabled in mid-frame: the running frame still ends
        fork
            frame(4'b0010, 8, 1'b1);
            begin
                repeat (3) @(posedge clk_i);
                host.wr_reg(RCV, 16'h0000);
            end
        join
        frame(4'b0010, 4, 1'b0);
        host.wr_reg(MCF, 16'hff17);
        rchk(MCF, 16'h3317);
        alloc(1'b1, 1'b1);
        rchk(MIN, 16'h1817);
        host.wr_reg(MCF, 16'h0017);
        alloc(1'b1, 1'b0);
        alloc(1'b0, 1'b1);
        mm_cmd(1'b1);
        rchk(MIN, 16'h1817);
        mm_cmd(1'b0);
        rchk(MIN, 16'h1818);
        rchk(MCF, 16'h3317);
        host.wr_reg(RCV, 16'h8306);
        rchk(RCV, 16'h8000);
        chk1("soft reset", 1'b1, srst_o);
        host.wr_reg(RCV, 16'h0000);
        rchk(RCV, 16'h0000);
        rchk(MCF, 16'h3300);
        chk16("reloads", 16'h0001, 16'(n_reload));
        // Hard reset in mid-run
        alloc(1'b0, 1'b1);
        @(posedge clk_i);
        srst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        srst_i <= 1'b0;
        rchk(MIN, 16'h1818);
        rchk(RCV, 16'h0000);
        chk16("reloads", 16'h0002, 16'(n_reload));
        give_verdict();
    end
endmodule : mac_rx_control_stats_memory_bench
